// >>> hdl/monitor_defines.svh
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH

// ==========================================================================
// Register port and field widths
`define REG_ADDR_W 13
`define PERIOD_W 24
`define DWELL_W 16
`define RESULT_W 20
`define DC_W 14
`define FRAME_W 40
`define FRAME_CNT_W 6

// ==========================================================================
// Register offsets
`define OFS_DWELL_LOW 13'h10A
`define OFS_DWELL_HIGH 13'h10B
`define OFS_DC_CTRL 13'h10C
`define OFS_DC_A_LOW 13'h10D
`define OFS_DC_A_HIGH 13'h10E
`define OFS_DC_B_LOW 13'h10F
`define OFS_DC_B_HIGH 13'h110
`define OFS_PORT_CTRL 13'h111
`define OFS_MON_CTRL 13'h112
`define OFS_PERIOD_0 13'h113
`define OFS_PERIOD_1 13'h114
`define OFS_PERIOD_2 13'h115
`define OFS_RES_A_0 13'h116
`define OFS_RES_A_1 13'h117
`define OFS_RES_A_2 13'h118
`define OFS_RES_B_0 13'h119
`define OFS_RES_B_1 13'h11A
`define OFS_RES_B_2 13'h11B

// ==========================================================================
// Reset values
`define RST_ZERO 8'h00
`define RST_PORT_CTRL 8'h04
`define RST_PERIOD_0 8'h40

// ==========================================================================
// Field positions
`define DC_MON_EN 0
`define DC_PATH_EN 1
`define DC_BW_LSB 2
`define DC_BW_MSB 5
`define DC_FREEZE 6
`define PC_OUT_EN 0
`define PC_SLEEP 1
`define PC_DIV_LSB 2
`define PC_DIV_MSB 3
`define PC_THR_EN 4
`define PC_PEAK_EN 5
`define PC_RMS_EN 6
`define MC_EN 0
`define MC_MODE_LSB 1
`define MC_MODE_MSB 2
`define MC_MS_SEL 3
`define MC_COMPLEX 7

// ==========================================================================
// Mode codes and serial clock divide codes
`define MODE_CODE_MAG 2'h0
`define MODE_CODE_PEAK 2'h1
`define DIV_CODE_4 2'h2
`define DIV_CODE_8 2'h3
`define HALF_TERM_2 2'h0
`define HALF_TERM_4 2'h1
`define HALF_TERM_8 2'h3

`endif

// >>> hdl/monitor_pkg.sv
// ==========================================================================
// Shared types
package monitor_pkg;

  // Content selected for the result registers
  typedef enum logic [1:0] {MODE_MAGNITUDE, MODE_PEAK, MODE_THRESHOLD} mon_mode_t;

  // Serial monitor output sequencer
  typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_t;

endpackage : monitor_pkg

// >>> hdl/frame_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Small FIFO between the period logic and the serial output
module frame_buffer #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q, rd_q;
  logic [PTR_W:0] cnt_q;
  logic push, pop;

  // Honest flags straight from the fill count
  assign in_ready = (cnt_q != DEPTH_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, one flop row per entry
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the configured depth
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      end
    end
  end

  // Fill count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : frame_buffer

`default_nettype wire

// >>> hdl/adc_signal_monitor_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defines.svh"

module adc_signal_monitor_registers #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port from the serial control port
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sample stream from the measurement arithmetic
  input wire logic sample_en,
  input wire logic below_fine_lower,
  input wire logic [`RESULT_W-1:0] meas_a,
  input wire logic [`RESULT_W-1:0] meas_b,
  input wire logic dc_calc_valid,
  input wire logic [`DC_W-1:0] dc_calc_a,
  input wire logic [`DC_W-1:0] dc_calc_b,
  // Controls to the measurement arithmetic
  output logic mon_enable,
  output monitor_pkg::mon_mode_t mon_mode,
  output logic ms_select,
  output logic complex_mode,
  output logic [3:0] dc_bandwidth,
  output logic dc_freeze,
  output logic dc_path_en,
  output logic dc_mon_en,
  output logic period_done,
  output logic increase_gain_flag,
  // Serial monitor output
  output logic monitor_serial_clk,
  output logic monitor_serial_data,
  output logic monitor_serial_frame
);

  // ========================================================================
  // Register storage
  logic [7:0] dwell_low_q, dwell_high_q, dc_ctrl_q, port_ctrl_q, mon_ctrl_q;
  logic [7:0] period_0_q, period_1_q, period_2_q;
  logic [`RESULT_W-1:0] result_a_q, result_b_q;
  logic [`DC_W-1:0] dc_a_q, dc_b_q;
  logic [7:0] reg_rdata_q;
  logic [`PERIOD_W-1:0] period_val, period_last, period_cnt_q;
  logic [`DWELL_W-1:0] dwell_val, dwell_cnt_q;
  logic gain_flag_q, period_end, push_want, stall, update;
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  logic [`FRAME_W-1:0] buf_out_data;
  logic word_enabled;

  // Writable registers; the rest ignore writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dwell_low_q <= `RST_ZERO;
      dwell_high_q <= `RST_ZERO;
      dc_ctrl_q <= `RST_ZERO;
      port_ctrl_q <= `RST_PORT_CTRL;
      mon_ctrl_q <= `RST_ZERO;
      period_0_q <= `RST_PERIOD_0;
      period_1_q <= `RST_ZERO;
      period_2_q <= `RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_DWELL_LOW: dwell_low_q <= reg_wdata;
        `OFS_DWELL_HIGH: dwell_high_q <= reg_wdata;
        `OFS_DC_CTRL: dc_ctrl_q <= reg_wdata;
        `OFS_PORT_CTRL: port_ctrl_q <= reg_wdata;
        `OFS_MON_CTRL: mon_ctrl_q <= reg_wdata;
        `OFS_PERIOD_0: period_0_q <= reg_wdata;
        `OFS_PERIOD_1: period_1_q <= reg_wdata;
        `OFS_PERIOD_2: period_2_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data registered one cycle after the address; open bits read zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= `RST_ZERO;
    end else begin
      case (reg_addr)
        `OFS_DWELL_LOW: reg_rdata_q <= dwell_low_q;
        `OFS_DWELL_HIGH: reg_rdata_q <= dwell_high_q;
        `OFS_DC_CTRL: reg_rdata_q <= {1'b0, dc_ctrl_q[6:0]};
        `OFS_DC_A_LOW: reg_rdata_q <= dc_a_q[7:0];
        `OFS_DC_A_HIGH: reg_rdata_q <= {2'b00, dc_a_q[13:8]};
        `OFS_DC_B_LOW: reg_rdata_q <= dc_b_q[7:0];
        `OFS_DC_B_HIGH: reg_rdata_q <= {2'b00, dc_b_q[13:8]};
        `OFS_PORT_CTRL: reg_rdata_q <= {1'b0, port_ctrl_q[6:0]};
        `OFS_MON_CTRL: reg_rdata_q <= {mon_ctrl_q[7], 3'b000, mon_ctrl_q[3:0]};
        `OFS_PERIOD_0: reg_rdata_q <= period_0_q;
        `OFS_PERIOD_1: reg_rdata_q <= period_1_q;
        `OFS_PERIOD_2: reg_rdata_q <= period_2_q;
        `OFS_RES_A_0: reg_rdata_q <= result_a_q[7:0];
        `OFS_RES_A_1: reg_rdata_q <= result_a_q[15:8];
        `OFS_RES_A_2: reg_rdata_q <= {4'h0, result_a_q[19:16]};
        `OFS_RES_B_0: reg_rdata_q <= result_b_q[7:0];
        `OFS_RES_B_1: reg_rdata_q <= result_b_q[15:8];
        `OFS_RES_B_2: reg_rdata_q <= {4'h0, result_b_q[19:16]};
        default: reg_rdata_q <= `RST_ZERO;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_q;

  // ========================================================================
  // Control decode towards the arithmetic
  assign dc_bandwidth = dc_ctrl_q[`DC_BW_MSB:`DC_BW_LSB];
  assign dc_freeze = dc_ctrl_q[`DC_FREEZE];
  assign dc_path_en = dc_ctrl_q[`DC_PATH_EN];
  assign dc_mon_en = dc_ctrl_q[`DC_MON_EN];
  assign mon_enable = mon_ctrl_q[`MC_EN];
  assign ms_select = mon_ctrl_q[`MC_MS_SEL];
  assign complex_mode = mon_ctrl_q[`MC_COMPLEX];

  // Both upper codes mean threshold crossing
  always_comb begin
    case (mon_ctrl_q[`MC_MODE_MSB:`MC_MODE_LSB])
      `MODE_CODE_MAG: mon_mode = monitor_pkg::MODE_MAGNITUDE;
      `MODE_CODE_PEAK: mon_mode = monitor_pkg::MODE_PEAK;
      default: mon_mode = monitor_pkg::MODE_THRESHOLD;
    endcase
  end

  // Latest dc offsets; freeze holds the last computed value
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dc_a_q <= '0;
      dc_b_q <= '0;
    end else if (dc_calc_valid && !dc_freeze) begin
      dc_a_q <= dc_calc_a;
      dc_b_q <= dc_calc_b;
    end
  end

  // ========================================================================
  // Increase-gain dwell: saturating count of consecutive low samples
  assign dwell_val = {dwell_high_q, dwell_low_q};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dwell_cnt_q <= '0;
      gain_flag_q <= 1'b0;
    end else if (sample_en) begin
      if (!below_fine_lower) begin
        dwell_cnt_q <= '0;
        gain_flag_q <= 1'b0;
      end else if (dwell_cnt_q >= dwell_val) begin
        gain_flag_q <= 1'b1;
      end else begin
        dwell_cnt_q <= dwell_cnt_q + 1'b1;
      end
    end
  end
  assign increase_gain_flag = gain_flag_q;

  // ========================================================================
  // Period counter; a full buffer stalls it at the last count
  assign period_val = {period_2_q, period_1_q, period_0_q};
  assign period_last = (period_val == '0) ? '0 : period_val - 1'b1;
  assign period_end = sample_en && mon_enable && (period_cnt_q >= period_last);
  always_comb begin
    case (mon_mode)
      monitor_pkg::MODE_MAGNITUDE: word_enabled = port_ctrl_q[`PC_RMS_EN];
      monitor_pkg::MODE_PEAK: word_enabled = port_ctrl_q[`PC_PEAK_EN];
      default: word_enabled = port_ctrl_q[`PC_THR_EN];
    endcase
  end
  assign push_want = period_end && port_ctrl_q[`PC_OUT_EN] && word_enabled;
  assign stall = push_want && !buf_in_ready;
  assign update = period_end && !stall;
  assign period_done = update;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      period_cnt_q <= '0;
    end else if (!mon_enable || update) begin
      period_cnt_q <= '0;
    end else if (sample_en && !period_end) begin
      period_cnt_q <= period_cnt_q + 1'b1;
    end
  end

  // Results change only at a period boundary, so reads stay coherent
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result_a_q <= '0;
      result_b_q <= '0;
    end else if (update) begin
      result_a_q <= meas_a;
      result_b_q <= meas_b;
    end
  end

  frame_buffer #(
    .WIDTH(`FRAME_W),
    .DEPTH(BUF_DEPTH)
  ) u_frame_buffer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(push_want),
    .in_ready(buf_in_ready),
    .in_data({meas_a, meas_b}),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ========================================================================
  // Serial monitor output: clock enable divider, data changes on falling edge
  monitor_pkg::ser_state_t ser_q;
  logic [1:0] div_cnt_q, half_term;
  logic [`FRAME_W-1:0] shift_q;
  logic [`FRAME_CNT_W-1:0] bits_q;
  logic sclk_q, frame_q, tick, load, sleeping;

  // Undefined code 00 falls back to divide by 2
  always_comb begin
    case (port_ctrl_q[`PC_DIV_MSB:`PC_DIV_LSB])
      `DIV_CODE_4: half_term = `HALF_TERM_4;
      `DIV_CODE_8: half_term = `HALF_TERM_8;
      default: half_term = `HALF_TERM_2;
    endcase
  end
  assign tick = (div_cnt_q >= half_term);
  assign sleeping = port_ctrl_q[`PC_SLEEP] && (ser_q == monitor_pkg::SER_IDLE);
  // Load only at a falling edge, or on a tick while sleep parks the clock low, so the first bit gets a full half period
  assign load = (ser_q == monitor_pkg::SER_IDLE) && tick && buf_out_valid
                && port_ctrl_q[`PC_OUT_EN] && (sclk_q || sleeping);
  assign buf_out_ready = load;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q <= '0;
    end else if (tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Serial clock: free running unless sleep parks it low while idle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
    end else if (load || (tick && sleeping)) begin
      sclk_q <= 1'b0;
    end else if (tick) begin
      sclk_q <= ~sclk_q;
    end
  end

  // Frame sequencer, channel A word first, most significant bit first
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ser_q <= monitor_pkg::SER_IDLE;
      shift_q <= '0;
      bits_q <= '0;
      frame_q <= 1'b0;
    end else begin
      case (ser_q)
        monitor_pkg::SER_IDLE: begin
          if (load) begin
            shift_q <= buf_out_data;
            bits_q <= `FRAME_CNT_W'(`FRAME_W);
            frame_q <= 1'b1;
            ser_q <= monitor_pkg::SER_SHIFT;
          end
        end
        monitor_pkg::SER_SHIFT: begin
          if (tick && sclk_q) begin
            if (bits_q == `FRAME_CNT_W'(1)) begin
              frame_q <= 1'b0;
              ser_q <= monitor_pkg::SER_IDLE;
            end else begin
              shift_q <= {shift_q[`FRAME_W-2:0], 1'b0};
              bits_q <= bits_q - 1'b1;
            end
          end
        end
        default: ser_q <= monitor_pkg::SER_IDLE;
      endcase
    end
  end
  assign monitor_serial_clk = sclk_q;
  assign monitor_serial_data = frame_q & shift_q[`FRAME_W-1];
  assign monitor_serial_frame = frame_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic [1:0] div_code_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_code_q <= 2'h0;
    end else begin
      div_code_q <= port_ctrl_q[`PC_DIV_MSB:`PC_DIV_LSB];
    end
  end

  a_period_restart: assert property (period_done |=> period_cnt_q == '0)
    else $error("period counter did not restart");
  a_result_latch: assert property (period_done |=> result_a_q == $past(meas_a)
    && result_b_q == $past(meas_b)) else $error("results not latched at period end");
  a_result_hold: assert property (!period_done |=> $stable(result_a_q))
    else $error("result changed inside a period");
  a_dc_freeze: assert property (dc_freeze |=> $stable(dc_a_q) && $stable(dc_b_q))
    else $error("dc value moved while frozen");
  a_gain_assert: assert property (sample_en && below_fine_lower
    && dwell_cnt_q >= dwell_val |=> increase_gain_flag) else $error("gain flag late");
  a_gain_clear: assert property (sample_en && !below_fine_lower
    |=> !increase_gain_flag ##0 dwell_cnt_q == '0) else $error("gain flag not cleared");
  a_mode_peak: assert property (reg_wr && reg_addr == `OFS_MON_CTRL
    && reg_wdata[2:1] == 2'h1 |=> mon_mode == monitor_pkg::MODE_PEAK)
    else $error("peak mode not selected");
  a_ms_follow: assert property (reg_wr && reg_addr == `OFS_MON_CTRL
    |=> ms_select == $past(reg_wdata[3])) else $error("rms/ms select wrong");
  a_div_eight: assert property ($changed(monitor_serial_clk) && div_code_q == 2'h3
    && port_ctrl_q[3:2] == 2'h3 && !load |=> $stable(monitor_serial_clk)[*3])
    else $error("serial clock divide by 8 wrong");
  a_read_result: assert property (reg_addr == `OFS_RES_A_2
    |=> reg_rdata == {4'h0, $past(result_a_q[19:16])}) else $error("result read wrong");

  c_period: cover property (period_done);
  c_frame: cover property (load ##[1:400] !monitor_serial_frame);
  c_stall: cover property (stall);
  c_gain: cover property ($rose(increase_gain_flag));

endmodule : adc_signal_monitor_registers

`default_nettype wire

// >>> verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Host controller on the register port
module host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [12:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle on an unmapped address with no strobe
  initial begin
    reg_addr = 13'h000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle strobe; data inverted afterwards so stale bytes never look valid
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge clk_sys);
    #10;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    // Quiet edge so a following write never re-raises the strobe at once
    @(posedge clk_sys);
    #10;
  endtask : wr

  // Read data is registered, so it is taken after the edge that saw the address
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    reg_addr = a;
    @(posedge clk_sys);
    #10;
    d = reg_rdata;
  endtask : rd
endmodule : host_model

`default_nettype wire

// >>> verif/test_adc_signal_monitor_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defines.svh"

module test_adc_signal_monitor_registers;
  // ==========================================================================
  // Signals
  logic clk_sys, arst_n, reg_wr, sample_en, below_fine_lower, dc_calc_valid;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [19:0] meas_a, meas_b;
  logic [13:0] dc_calc_a, dc_calc_b;
  logic mon_enable, ms_select, complex_mode, dc_freeze, dc_path_en, dc_mon_en;
  logic period_done, increase_gain_flag, sclk, sdata, sframe, pd;
  logic [3:0] dc_bandwidth;
  monitor_pkg::mon_mode_t mon_mode;
  int err_total = 0;
  int comparisons = 0;

  // Clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  adc_signal_monitor_registers dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_en(sample_en),
    .below_fine_lower(below_fine_lower), .meas_a(meas_a), .meas_b(meas_b),
    .dc_calc_valid(dc_calc_valid), .dc_calc_a(dc_calc_a), .dc_calc_b(dc_calc_b),
    .mon_enable(mon_enable), .mon_mode(mon_mode), .ms_select(ms_select),
    .complex_mode(complex_mode), .dc_bandwidth(dc_bandwidth), .dc_freeze(dc_freeze),
    .dc_path_en(dc_path_en), .dc_mon_en(dc_mon_en), .period_done(period_done),
    .increase_gain_flag(increase_gain_flag), .monitor_serial_clk(sclk),
    .monitor_serial_data(sdata), .monitor_serial_frame(sframe));

  host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ==========================================================================
  // Helpers
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
    host_u.rd(a, rv);
    chk($sformatf("reg %0h", a), rv, exp);
  endtask : rdc

  // Two samples; period_done is looked at during the second
  task automatic per(output logic seen);
    sample_en = 1'b1;
    @(posedge clk_sys);
    #10;
    seen = period_done;
    @(posedge clk_sys);
    #10;
    sample_en = 1'b0;
    // One quiet edge so a following sample never re-raises the enable at once
    @(posedge clk_sys);
    #10;
  endtask : per

  task automatic test_done;
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [12:0] ra[9];
    logic [7:0] rvals[9];
    ra = '{`OFS_DWELL_LOW, `OFS_DWELL_HIGH, `OFS_DC_CTRL, `OFS_PORT_CTRL, `OFS_MON_CTRL,
      `OFS_PERIOD_0, `OFS_PERIOD_1, `OFS_PERIOD_2, 13'h11C};
    rvals = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rdc(ra[i], rvals[i]);
    chk("dc ctrl", {dc_freeze, dc_bandwidth, dc_path_en, dc_mon_en}, 40'h0);
  endtask : t_reset

  task automatic t_dc;
    dc_calc_a = 14'h3ABC;
    dc_calc_b = 14'h1357;
    dc_calc_valid = 1'b1;
    @(posedge clk_sys);
    #10;
    dc_calc_valid = 1'b0;
    rdc(`OFS_DC_A_LOW, 8'hBC);
    rdc(`OFS_DC_A_HIGH, 8'h3A);
    rdc(`OFS_DC_B_LOW, 8'h57);
    rdc(`OFS_DC_B_HIGH, 8'h13);
    host_u.wr(`OFS_DC_A_LOW, 8'h11);
    rdc(`OFS_DC_A_LOW, 8'hBC);
    // Freeze holds the last value across a fresh result
    host_u.wr(`OFS_DC_CTRL, 8'h40);
    dc_calc_a = 14'h0123;
    dc_calc_valid = 1'b1;
    @(posedge clk_sys);
    #10;
    dc_calc_valid = 1'b0;
    rdc(`OFS_DC_A_LOW, 8'hBC);
  endtask : t_dc

  task automatic t_fields;
    host_u.wr(`OFS_DC_CTRL, 8'hFF);
    rdc(`OFS_DC_CTRL, 8'h7F);
    chk("dc ctrl", {dc_freeze, dc_bandwidth, dc_path_en, dc_mon_en}, 40'h7F);
    host_u.wr(`OFS_DC_CTRL, 8'h14);
    chk("dc bw", dc_bandwidth, 40'h5);
    host_u.wr(`OFS_PORT_CTRL, 8'hFF);
    rdc(`OFS_PORT_CTRL, 8'h7F);
    host_u.wr(`OFS_PORT_CTRL, 8'h00);
    host_u.wr(`OFS_MON_CTRL, 8'hFF);
    rdc(`OFS_MON_CTRL, 8'h8F);
    chk("complex", complex_mode, 40'h1);
  endtask : t_fields

  task automatic t_modes;
    logic [1:0] exp;
    for (int m = 0; m < 4; m++) begin
      host_u.wr(`OFS_MON_CTRL, 8'(m * 2 + (m % 2) * 8));
      exp = (m == 0) ? 2'h0 : (m == 1) ? 2'h1 : 2'h2;
      chk("mode", mon_mode, exp);
      chk("ms sel", ms_select, 40'(m % 2));
    end
  endtask : t_modes

  task automatic t_dwell;
    host_u.wr(`OFS_DWELL_LOW, 8'h03);
    host_u.wr(`OFS_DWELL_HIGH, 8'h00);
    below_fine_lower = 1'b1;
    for (int i = 0; i < 4; i++) begin
      sample_en = 1'b1;
      @(posedge clk_sys);
      #10;
      sample_en = 1'b0;
      @(posedge clk_sys);
      #10;
      chk("gain flag", increase_gain_flag, 40'(i == 3));
    end
    below_fine_lower = 1'b0;
    per(pd);
    chk("gain flag clr", increase_gain_flag, 40'h0);
  endtask : t_dwell

  task automatic t_period;
    host_u.wr(`OFS_PERIOD_0, 8'h02);
    host_u.wr(`OFS_PERIOD_1, 8'h00);
    host_u.wr(`OFS_MON_CTRL, 8'h01);
    chk("mon en", mon_enable, 40'h1);
    meas_a = 20'hABCDE;
    meas_b = 20'h5F312;
    chk("done idle", period_done, 40'h0);
    per(pd);
    chk("done", pd, 40'h1);
    meas_a = 20'h0;
    meas_b = 20'h0;
    rdc(`OFS_RES_A_0, 8'hDE);
    rdc(`OFS_RES_A_1, 8'hBC);
    rdc(`OFS_RES_A_2, 8'h0A);
    rdc(`OFS_RES_B_0, 8'h12);
    rdc(`OFS_RES_B_1, 8'hF3);
    rdc(`OFS_RES_B_2, 8'h05);
  endtask : t_period

  task automatic t_serial;
    logic [39:0] word;
    int nb, t1, t2, n;
    logic ps;
    for (int c = 1; c < 4; c++) begin
      host_u.wr(`OFS_PORT_CTRL, 8'(8'h41 | (c << 2)));
      meas_a = 20'hC3A50 ^ 20'(c);
      meas_b = 20'h0F1E2 + 20'(c);
      per(pd);
      word = 40'h0;
      nb = 0;
      ps = sclk;
      n = 0;
      while (n < 600 && !(nb > 0 && !sframe)) begin
        @(posedge clk_sys);
        #10;
        n++;
        if (sframe && sclk && !ps) begin
          word = {word[38:0], sdata};
          nb++;
          if (nb == 1) t1 = n;
          if (nb == 2) t2 = n;
        end
        ps = sclk;
      end
      chk("bits", nb, 40'd40);
      chk("word", word, {meas_a, meas_b});
      chk("half period", (t2 - t1) / 2, 40'(1 << (c - 1)));
    end
    // Sleep parks the serial clock low while nothing waits to be sent
    host_u.wr(`OFS_PORT_CTRL, 8'h03);
    repeat (6) begin
      @(posedge clk_sys);
      #10;
      chk("sleep clk", sclk, 40'h0);
    end
  endtask : t_serial

  task automatic t_stall;
    int n;
    host_u.wr(`OFS_PORT_CTRL, 8'h4D);
    per(pd);
    repeat (20) @(posedge clk_sys);
    #10;
    per(pd);
    chk("push 2", pd, 40'h1);
    per(pd);
    chk("push 3", pd, 40'h1);
    // Buffer full: period end must wait, not drop a word
    sample_en = 1'b1;
    @(posedge clk_sys);
    #10;
    n = 0;
    chk("stalled", period_done, 40'h0);
    while (n < 900 && period_done !== 1'b1) begin
      @(posedge clk_sys);
      #10;
      n++;
    end
    // Look while the retried period end still stands, then let it land
    chk("resumed", period_done, 40'h1);
    @(posedge clk_sys);
    #10;
    sample_en = 1'b0;
    host_u.wr(`OFS_PORT_CTRL, 8'h04);
  endtask : t_stall

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    arst_n = 1'b0;
    sample_en = 1'b0;
    below_fine_lower = 1'b0;
    dc_calc_valid = 1'b0;
    meas_a = 20'h0;
    meas_b = 20'h0;
    dc_calc_a = 14'h0;
    dc_calc_b = 14'h0;
    repeat (6) @(posedge clk_sys);
    #10;
    arst_n = 1'b1;
    t_reset();
    t_dc();
    t_fields();
    t_modes();
    t_dwell();
    t_period();
    t_serial();
    t_stall();
    test_done();
  end

  // Cuts a hang short well past the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
endmodule : test_adc_signal_monitor_registers

`default_nettype wire
